/* File: verilog/vcpu_ack_if.sv */
// Virtual CPU interface: acknowledge, highest pending and group 0 enable
`timescale 1ns/1ns
// Contract
// [RULE1] Group 0 acknowledge read returns and acknowledges
// [RULE2] Group 1 acknowledge read returns and acknowledges
// [RULE3] Return highest pending if signallable and acknowledgeable
// [RULE4] Unobservable interrupt returns number 1023
// [RULE5] Number bits 23:0, 16-bit mode zeroes 23:16
// [RULE6] Group 0 acknowledge virtual only when fiq routed
// [RULE7] Group 1 acknowledge virtual only when irq routed
// [RULE8] Group 0 enable virtual only when fiq routed
// [RULE9] Group 1 highest pending virtual when irq routed
// [RULE10] Coprocessor trap bit traps to hypervisor
// [RULE11] Sysreg enable zero traps kernel, or undefined
// [RULE12] Trap-all bits trap their group to hypervisor
// [RULE13] Enable bit 0 gates group 0, rest zero
// [RULE14] Group 0 enable resets to zero
// [RULE15] Registers 32 bits; acknowledge read-only, enable read-write
// [RULE16] Decode by CRn, CRm and opc2 fields
// [RULE17] Highest pending reports without acknowledging
// [RULE18] Acknowledge marks active, raises running priority
// [RULE19] Disabled group acknowledge returns special number
module vcpu_ack_if
   import vcpu_ack_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              acc_valid,
   input  wire logic              acc_write,
   input  wire logic              acc_ns_kernel,
   input  wire logic              acc_state32,
   input  wire logic [2:0]        acc_opc1,
   input  wire logic [3:0]        acc_crn,
   input  wire logic [3:0]        acc_crm,
   input  wire logic [2:0]        acc_opc2,
   input  wire logic [31:0]       acc_wdata,
   input  wire logic              fiq_routing_control,
   input  wire logic              irq_routing_control,
   input  wire logic              coprocessor_group_trap_bit,
   input  wire logic              guest_sysreg_enable_bit,
   input  wire logic              trap_all_group0_bit,
   input  wire logic              trap_all_group1_bit,
   input  wire logic              identifier_width_field,
   input  wire logic [7:0]        priority_mask,
   input  wire logic              group1_enable,
   input  wire logic              lr_we,
   input  wire logic [LR_AW-1:0]  lr_waddr,
   input  wire logic [LR_W-1:0]   lr_wdata,
   input  wire logic              lr_group1_in,
   output logic                   acc_done,
   output logic [4:0]             acc_result,
   output logic [31:0]            acc_rdata,
   output logic                   ack_pulse,
   output logic [LR_AW-1:0]       ack_index,
   output logic [7:0]             running_priority,
   output logic                   virtual_group0_enable
);
   // Group of each list entry held beside the memory
   logic [LR_N-1:0]  grp1_q;
   logic [LR_N-1:0]  act_clr_q;
   state_t           state_q;
   logic             is_ack_q;
   logic             is_hpend_q;
   logic             is_grp1_q;
   logic [LR_AW-1:0] scan_q;
   logic [LR_AW-1:0] rd_idx_q;
   logic             scan_live_q;
   logic             best_vld_q;
   logic [LR_AW-1:0] best_idx_q;
   logic [7:0]       best_prio_q;
   logic [23:0]      best_num_q;
   logic [LR_W-1:0]  rd_word;
   logic             mem_we;
   logic [LR_AW-1:0] mem_waddr;
   logic [LR_W-1:0]  mem_wdata;
   logic [LR_W-1:0]  act_word_q;
   logic             act_pend_q;

   // Decode and permission checks
   logic    dec_grp0_ack;
   logic    dec_grp1_ack;
   logic    dec_grp0_en;
   logic    dec_grp1_hp;
   logic    dec_hit;
   logic    dec_grp0;
   logic    route_virt;
   result_t res_d;

   // Field decode of the instruction
   assign dec_hit      = acc_crn == CRN_CPUIF && acc_opc1 == OPC1_CPUIF; // [RULE16]
   assign dec_grp0_ack = dec_hit && acc_crm == CRM_GRP0 && acc_opc2 == OPC2_ACK; // [RULE16]
   assign dec_grp1_ack = dec_hit && acc_crm == CRM_GRP1 && acc_opc2 == OPC2_ACK; // [RULE16]
   assign dec_grp0_en  = dec_hit && acc_crm == CRM_GRP1 && acc_opc2 == OPC2_GRP0_EN; // [RULE16]
   assign dec_grp1_hp  = dec_hit && acc_crm == CRM_GRP1 && acc_opc2 == OPC2_HPEND; // [RULE16]
   assign dec_grp0     = dec_grp0_ack || dec_grp0_en;
   // Group 0 registers follow fiq routing, group 1 follow irq routing
   assign route_virt   = dec_grp0 ? fiq_routing_control : irq_routing_control; // [RULE6] [RULE7] [RULE8] [RULE9]

   // Outcome priority: sysreg enable (undefined or kernel trap), routing, hypervisor traps, then write undefined
   always_comb begin
      res_d = RES_OK;
      if (!guest_sysreg_enable_bit) begin
         res_d = acc_state32 ? RES_UNDEF : RES_KERN; // [RULE11]
      end else if (!route_virt) begin
         res_d = RES_PHYS; // [RULE6] [RULE7] [RULE8] [RULE9]
      end else if (coprocessor_group_trap_bit) begin
         res_d = RES_HYP; // [RULE10]
      end else if (dec_grp0 ? trap_all_group0_bit : trap_all_group1_bit) begin
         res_d = RES_HYP; // [RULE12]
      end else if (acc_write && !dec_grp0_en) begin
         res_d = RES_UNDEF; // [RULE15]
      end
   end

   logic take;
   assign take = acc_valid && acc_ns_kernel && state_q == ST_IDLE &&
                 (dec_grp0_ack || dec_grp1_ack || dec_grp0_en || dec_grp1_hp);

   // Access state: idle, scan list, answer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take && res_d == RES_OK && !dec_grp0_en) begin
                  state_q <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               if (scan_live_q && rd_idx_q == LR_AW'(LR_N - 1)) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Latch the kind of access being served
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         is_ack_q   <= 1'b0;
         is_hpend_q <= 1'b0;
         is_grp1_q  <= 1'b0;
      end else if (take) begin
         is_ack_q   <= dec_grp0_ack || dec_grp1_ack;
         is_hpend_q <= dec_grp1_hp;
         is_grp1_q  <= !dec_grp0;
      end
   end

   // Walk the list one entry per cycle; read data lags address by one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scan_q      <= '0;
         rd_idx_q    <= '0;
         scan_live_q <= 1'b0;
      end else if (state_q == ST_SCAN) begin
         scan_q      <= scan_q + 1'b1;
         rd_idx_q    <= scan_q;
         scan_live_q <= 1'b1;
      end else begin
         scan_q      <= '0;
         rd_idx_q    <= '0;
         scan_live_q <= 1'b0;
      end
   end

   // Candidate: pending, not active, right group; acknowledge reads also need enabled, above mask
   logic cand;
   logic grp_en;
   assign grp_en = is_grp1_q ? group1_enable : virtual_group0_enable; // [RULE19]
   assign cand = scan_live_q && rd_word[32] && !rd_word[33] &&
                 grp1_q[rd_idx_q] == is_grp1_q &&
                 (is_hpend_q || (grp_en && rd_word[31:24] < priority_mask &&
                                 rd_word[31:24] < running_priority)); // [RULE3] [RULE19]

   // Keep the best candidate; lower value wins, first index on ties
   always_ff @(posedge clk) begin
      if (sys_rst || state_q == ST_IDLE) begin
         best_vld_q  <= 1'b0;
         best_idx_q  <= '0;
         best_prio_q <= IDLE_PRIO;
         best_num_q  <= SPURIOUS_NUM;
      end else if (cand && (!best_vld_q || rd_word[31:24] < best_prio_q)) begin
         best_vld_q  <= 1'b1; // [RULE3]
         best_idx_q  <= rd_idx_q;
         best_prio_q <= rd_word[31:24];
         best_num_q  <= rd_word[23:0];
      end
   end

   // Returned number: 1023 when nothing observable, narrowed in 16-bit mode
   logic [23:0] num_out;
   assign num_out = (best_vld_q ? best_num_q : SPURIOUS_NUM) &
                    (identifier_width_field ? {NUM_W{1'b1}} : NUM16_MASK); // [RULE4] [RULE5]

   // Answer to the core
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_done   <= 1'b0;
         acc_result <= RES_OK;
         acc_rdata  <= '0;
      end else if (take && !(res_d == RES_OK && !dec_grp0_en)) begin
         acc_done   <= 1'b1;
         acc_result <= res_d;
         acc_rdata  <= (res_d == RES_OK && !acc_write) ?
                       {31'h0, virtual_group0_enable} : 32'h0; // [RULE13] [RULE15]
      end else if (state_q == ST_DONE) begin
         acc_done   <= 1'b1;
         acc_result <= RES_OK;
         acc_rdata  <= {8'h00, num_out}; // [RULE1] [RULE2] [RULE5] [RULE17]
      end else begin
         acc_done   <= 1'b0;
         acc_result <= acc_result;
         acc_rdata  <= acc_rdata;
      end
   end

   // Group 0 enable register, bit 0 only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         virtual_group0_enable <= ENABLE_RST; // [RULE14]
      end else if (take && dec_grp0_en && acc_write && res_d == RES_OK) begin
         virtual_group0_enable <= acc_wdata[ENABLE_BIT]; // [RULE8] [RULE13]
      end
   end

   // Acknowledge only from acknowledge reads, never the pending query
   logic ack_now;
   assign ack_now = state_q == ST_DONE && is_ack_q && best_vld_q; // [RULE1] [RULE2] [RULE17]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_pulse        <= 1'b0;
         ack_index        <= '0;
         running_priority <= IDLE_PRIO;
      end else begin
         ack_pulse <= ack_now;
         if (ack_now) begin
            ack_index        <= best_idx_q;
            running_priority <= best_prio_q; // [RULE18]
         end
      end
   end

   // Second cycle of acknowledge: rewrite entry as active, not pending.
   // Done from the latched word, so a list write the same cycle wins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         act_pend_q <= 1'b0;
         act_word_q <= '0;
      end else begin
         act_pend_q <= ack_now;
         act_word_q <= {2'b10, best_prio_q, best_num_q}; // [RULE18]
      end
   end

   // Group tags ride alongside list writes
   genvar gi;
   generate
      for (gi = 0; gi < LR_N; gi++) begin : g_grp
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               grp1_q[gi] <= 1'b0;
            end else if (lr_we && lr_waddr == LR_AW'(gi)) begin
               grp1_q[gi] <= lr_group1_in;
            end
         end
         assign act_clr_q[gi] = act_pend_q && ack_index == LR_AW'(gi) &&
                                !(lr_we && lr_waddr == LR_AW'(gi));
      end
   endgenerate

   assign mem_we    = lr_we || (|act_clr_q);
   assign mem_waddr = lr_we ? lr_waddr : ack_index;
   assign mem_wdata = lr_we ? lr_wdata : act_word_q;

   vcpu_list_mem u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (scan_q),
      .rdata (rd_word)
   );

   // Checks
   sequence s_ack_done;
      ack_pulse;
   endsequence

   a_reset_enable: assert property (@(posedge clk) // [RULE14]
      sys_rst |=> !virtual_group0_enable)
      else $error("enable not cleared by reset");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      acc_done |-> acc_rdata[31:24] == 8'h00)
      else $error("reserved bits set");
   a_narrow_num: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      acc_done && !$past(identifier_width_field) |-> acc_rdata[23:16] == 8'h00)
      else $error("upper number bits in 16-bit mode");
   a_phys_route: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
      take && guest_sysreg_enable_bit && dec_grp0 && !fiq_routing_control
      |=> acc_done && acc_result == RES_PHYS)
      else $error("group 0 not routed physical");
   a_irq_route: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      take && guest_sysreg_enable_bit && !dec_grp0 && !irq_routing_control
      |=> acc_done && acc_result == RES_PHYS)
      else $error("group 1 not routed physical");
   a_cp_trap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      take && guest_sysreg_enable_bit && route_virt && coprocessor_group_trap_bit
      |=> acc_result == RES_HYP)
      else $error("coprocessor trap missed");
   a_sre_trap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      take && !guest_sysreg_enable_bit |=> acc_result inside {RES_KERN, RES_UNDEF})
      else $error("sysreg enable trap missed");
   a_hp_no_ack: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
      take && dec_grp1_hp |-> ##1 !ack_pulse [*8])
      else $error("pending query acknowledged");
   a_ack_prio: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
      s_ack_done |-> running_priority < IDLE_PRIO && acc_done)
      else $error("running priority not raised");

   // A list read answers a fixed seven edges after the take, never later
   sequence s_scan_start;
      take && res_d == RES_OK && !dec_grp0_en;
   endsequence

   a_scan_answer: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1] [RULE2]
      s_scan_start |-> ##7 acc_done)
      else $error("list read not answered in time");
   a_spur_num: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
      state_q == ST_DONE && !best_vld_q |=> acc_rdata[23:0] == SPURIOUS_NUM)
      else $error("special number not returned");
   a_trap_all: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      take && guest_sysreg_enable_bit && route_virt && !coprocessor_group_trap_bit &&
      (dec_grp0 ? trap_all_group0_bit : trap_all_group1_bit)
      |=> acc_done && acc_result == RES_HYP)
      else $error("trap-all bit missed");
   a_enable_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
      take && dec_grp0_en && acc_write && res_d == RES_OK
      |=> virtual_group0_enable == $past(acc_wdata[ENABLE_BIT]))
      else $error("enable write lost");
   a_enable_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8] [RULE15]
      !(take && dec_grp0_en && acc_write && res_d == RES_OK)
      |=> $stable(virtual_group0_enable))
      else $error("enable changed without a write");
endmodule

/* File: verilog/vcpu_ack_pkg.sv */
// Constants and types for the virtual acknowledge and group 0 enable block
package vcpu_ack_pkg;
   // Coprocessor field encodings
   localparam logic [3:0] CRN_CPUIF      = 4'hc;
   localparam logic [3:0] CRM_GRP0       = 4'h8;
   localparam logic [3:0] CRM_GRP1       = 4'hc;
   localparam logic [2:0] OPC2_ACK       = 3'h0;
   localparam logic [2:0] OPC2_HPEND     = 3'h2;
   localparam logic [2:0] OPC2_GRP0_EN   = 3'h6;
   localparam logic [2:0] OPC1_CPUIF     = 3'h0;
   // Interrupt number field, group 0 enable bit and idle priority
   localparam int          NUM_W         = 24;
   localparam logic [23:0] SPURIOUS_NUM  = 24'h0003ff;
   localparam logic [23:0] NUM16_MASK    = 24'h00ffff;
   localparam int          ENABLE_BIT    = 0;
   localparam logic        ENABLE_RST    = 1'b0;
   localparam logic [7:0]  IDLE_PRIO     = 8'hff;
   // Table of virtual interrupts held in the list memory
   localparam int          LR_N          = 4;
   localparam int          LR_AW         = 2;
   localparam int          LR_W          = 34; // [33]act [32]pend [31:24]prio [23:0]num
   // Access outcome
   typedef enum logic [4:0] {
      RES_OK    = 5'b00001,
      RES_PHYS  = 5'b00010,
      RES_HYP   = 5'b00100,
      RES_KERN  = 5'b01000,
      RES_UNDEF = 5'b10000
   } result_t;
   // Access state machine
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SCAN = 3'b010,
      ST_DONE = 3'b100
   } state_t;
endpackage

/* File: verilog/vcpu_list_mem.sv */
// Small list memory holding virtual interrupt entries, registered read
`timescale 1ns/1ns
module vcpu_list_mem
   import vcpu_ack_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              we,
   input  wire logic [LR_AW-1:0]  waddr,
   input  wire logic [LR_W-1:0]   wdata,
   input  wire logic [LR_AW-1:0]  raddr,
   output logic      [LR_W-1:0]   rdata
);
   logic [LR_W-1:0] mem_q [LR_N];

   // Write port
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Read data leaves from a register
   always_ff @(posedge clk) begin
      rdata <= mem_q[raddr];
   end
endmodule

/* File: tb/core_access_model.sv */
// Processor core model that issues coprocessor register accesses
`timescale 1ns/1ns
module core_access_model
   import vcpu_ack_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        acc_done,
   input  wire logic [4:0]  acc_result,
   input  wire logic [31:0] acc_rdata,
   input  wire logic        ack_pulse,
   output logic             acc_valid,
   output logic             acc_write,
   output logic             acc_ns_kernel,
   output logic [2:0]       acc_opc1,
   output logic [3:0]       acc_crn,
   output logic [3:0]       acc_crm,
   output logic [2:0]       acc_opc2,
   output logic [31:0]      acc_wdata
);
   // Idle state at time zero
   initial begin
      acc_valid = 1'b0;
      acc_write = 1'b0;
      acc_ns_kernel = 1'b0;
      acc_opc1 = 3'h7;
      acc_crn = 4'h0;
      acc_crm = 4'h0;
      acc_opc2 = 3'h0;
      acc_wdata = 32'h0;
   end

   // One request, held one cycle, then a bounded wait for the answer
   task automatic issue(input logic wr, input logic kern, input logic [3:0] crm,
                        input logic [2:0] op2, input logic [31:0] wd, output logic got,
                        output logic [4:0] res, output logic [31:0] rd, output logic pls);
      got = 1'b0;
      res = 5'h0;
      rd = 32'h0;
      pls = 1'b0;
      @(negedge clk);
      acc_valid <= 1'b1;
      acc_write <= wr;
      acc_ns_kernel <= kern;
      acc_opc1 <= OPC1_CPUIF;
      acc_crn <= CRN_CPUIF;
      acc_crm <= crm;
      acc_opc2 <= op2;
      acc_wdata <= wd;
      @(negedge clk);
      // Released fields other than acc_opc1 and acc_ns_kernel show the inverse so a stale value can never look valid
      acc_valid <= 1'b0;
      acc_write <= ~wr;
      acc_crn <= ~CRN_CPUIF;
      acc_crm <= ~crm;
      acc_opc2 <= ~op2;
      acc_wdata <= ~wd;
      for (int i = 0; i < 12 && !got; i++) begin
         if (acc_done === 1'b1) begin
            got = 1'b1;
            res = acc_result;
            rd = acc_rdata;
            pls = ack_pulse;
         end else begin
            @(negedge clk);
         end
      end
   endtask
endmodule

/* File: tb/test_virtual_cpu_if_ack_and_group0_enable.sv */
// Self-checking bench for the virtual acknowledge and group 0 enable block
`timescale 1ns/1ns
module test_virtual_cpu_if_ack_and_group0_enable
   import vcpu_ack_pkg::*;
;
   logic             clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic             acc_state32 = 1'b0;
   logic             fiq_routing_control = 1'b1;
   logic             irq_routing_control = 1'b1;
   logic             coprocessor_group_trap_bit = 1'b0;
   logic             guest_sysreg_enable_bit = 1'b1;
   logic             trap_all_group0_bit = 1'b0;
   logic             trap_all_group1_bit = 1'b0;
   logic             identifier_width_field = 1'b1;
   logic [7:0]       priority_mask = 8'hf0;
   logic             group1_enable = 1'b1;
   logic             lr_we = 1'b0;
   logic [LR_AW-1:0] lr_waddr = 2'h0;
   logic [LR_W-1:0]  lr_wdata = 34'h0;
   logic             lr_group1_in = 1'b0;
   wire              acc_valid, acc_write, acc_ns_kernel, acc_done, ack_pulse;
   wire  [2:0]       acc_opc1, acc_opc2;
   wire  [3:0]       acc_crn, acc_crm;
   wire  [31:0]      acc_wdata, acc_rdata;
   wire  [4:0]       acc_result;
   wire  [LR_AW-1:0] ack_index;
   wire  [7:0]       running_priority;
   wire              virtual_group0_enable;
   logic             got, pls;
   logic [4:0]       res;
   logic [31:0]      rd;
   int               failures = 0;
   int               checks_done = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   vcpu_ack_if u_vcpu_ack_if (.clk, .sys_rst, .acc_valid, .acc_write, .acc_ns_kernel,
      .acc_state32, .acc_opc1, .acc_crn, .acc_crm, .acc_opc2, .acc_wdata,
      .fiq_routing_control, .irq_routing_control, .coprocessor_group_trap_bit,
      .guest_sysreg_enable_bit, .trap_all_group0_bit, .trap_all_group1_bit,
      .identifier_width_field, .priority_mask, .group1_enable, .lr_we, .lr_waddr,
      .lr_wdata, .lr_group1_in, .acc_done, .acc_result, .acc_rdata, .ack_pulse,
      .ack_index, .running_priority, .virtual_group0_enable);

   core_access_model u_core_access_model (.clk, .acc_done, .acc_result, .acc_rdata,
      .ack_pulse, .acc_valid, .acc_write, .acc_ns_kernel, .acc_opc1, .acc_crn, .acc_crm,
      .acc_opc2, .acc_wdata);

   task automatic tally_and_finish();
      if (failures == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected number field, narrowed when only 16 bits are implemented
   function automatic logic [31:0] num(input logic [23:0] n);
      return {8'h00, identifier_width_field ? n : (n & NUM16_MASK)};
   endfunction

   // A missing or unwanted answer ends the run at once
   task automatic acc(input logic wr, input logic kern, input logic [3:0] crm,
                      input logic [2:0] op2, input logic [31:0] wd, input logic ed);
      u_core_access_model.issue(wr, kern, crm, op2, wd, got, res, rd, pls);
      check({31'h0, got}, {31'h0, ed});
      if (got !== ed) tally_and_finish();
   endtask

   task automatic rd_chk(input logic [3:0] crm, input logic [2:0] op2,
                         input logic [31:0] exp, input logic ep);
      acc(1'b0, 1'b1, crm, op2, 32'h0, 1'b1);
      check({27'h0, res}, {27'h0, RES_OK});
      check(rd, exp);
      check({31'h0, pls}, {31'h0, ep});
   endtask

   task automatic lr(input logic [1:0] a, input logic g1, input logic p,
                     input logic [7:0] pr, input logic [23:0] n);
      @(negedge clk);
      lr_we = 1'b1;
      lr_waddr = a;
      lr_group1_in = g1;
      lr_wdata = {1'b0, p, pr, n};
      @(negedge clk);
      lr_we = 1'b0;
   endtask

   task automatic set_ctl(input logic [6:0] c);
      {guest_sysreg_enable_bit, acc_state32, fiq_routing_control, irq_routing_control,
       coprocessor_group_trap_bit, trap_all_group0_bit, trap_all_group1_bit} = c;
   endtask

   // Trapped or redirected access: outcome code, and nothing acknowledged
   task automatic tr(input logic [6:0] c, input logic wr, input logic [3:0] crm,
                     input logic [2:0] op2, input logic [4:0] exp);
      set_ctl(c);
      acc(wr, 1'b1, crm, op2, 32'h0, 1'b1);
      check({27'h0, res}, {27'h0, exp});
      check({31'h0, pls}, 32'h0);
      set_ctl(7'b1011000);
   endtask

   task automatic t_reset();
      check({31'h0, virtual_group0_enable}, 32'h0);
      rd_chk(CRM_GRP1, OPC2_GRP0_EN, 32'h0, 1'b0);
      rd_chk(CRM_GRP0, OPC2_ACK, 32'h3ff, 1'b0);
   endtask

   task automatic t_enable();
      acc(1'b1, 1'b1, CRM_GRP1, OPC2_GRP0_EN, 32'hffff_fffe, 1'b1);
      check({31'h0, virtual_group0_enable}, 32'h0);
      acc(1'b1, 1'b1, CRM_GRP1, OPC2_GRP0_EN, 32'hffff_ffff, 1'b1);
      check({31'h0, virtual_group0_enable}, 32'h1);
      rd_chk(CRM_GRP1, OPC2_GRP0_EN, 32'h1, 1'b0);
   endtask

   task automatic t_ack0();
      rd_chk(CRM_GRP0, OPC2_ACK, num(24'h000020), 1'b1);
      check({30'h0, ack_index}, 32'h0);
      check({24'h0, running_priority}, 32'h30);
      rd_chk(CRM_GRP0, OPC2_ACK, 32'h3ff, 1'b0);
   endtask

   task automatic t_grp1();
      identifier_width_field = 1'b0;
      rd_chk(CRM_GRP1, OPC2_HPEND, num(24'h1abcde), 1'b0);
      identifier_width_field = 1'b1;
      group1_enable = 1'b0;
      rd_chk(CRM_GRP1, OPC2_ACK, 32'h3ff, 1'b0);
      group1_enable = 1'b1;
      priority_mask = 8'h20;
      rd_chk(CRM_GRP1, OPC2_ACK, 32'h3ff, 1'b0);
      priority_mask = 8'hf0;
      rd_chk(CRM_GRP1, OPC2_ACK, num(24'h1abcde), 1'b1);
      check({30'h0, ack_index}, 32'h1);
      check({24'h0, running_priority}, 32'h20);
      rd_chk(CRM_GRP1, OPC2_HPEND, num(24'h000040), 1'b0);
      rd_chk(CRM_GRP1, OPC2_ACK, 32'h3ff, 1'b0);
   endtask

   // Control bits: sysreg enable, 32-bit state, fiq, irq, coproc trap, trap-all 0, 1
   task automatic t_traps();
      tr(7'b0011000, 1'b0, CRM_GRP0, OPC2_ACK, RES_KERN);
      tr(7'b0111000, 1'b0, CRM_GRP0, OPC2_ACK, RES_UNDEF);
      tr(7'b1001000, 1'b0, CRM_GRP0, OPC2_ACK, RES_PHYS);
      tr(7'b1010000, 1'b0, CRM_GRP1, OPC2_ACK, RES_PHYS);
      tr(7'b1001000, 1'b1, CRM_GRP1, OPC2_GRP0_EN, RES_PHYS);
      tr(7'b1010000, 1'b0, CRM_GRP1, OPC2_HPEND, RES_PHYS);
      tr(7'b1011100, 1'b0, CRM_GRP1, OPC2_ACK, RES_HYP);
      tr(7'b1011010, 1'b1, CRM_GRP1, OPC2_GRP0_EN, RES_HYP);
      tr(7'b1011001, 1'b0, CRM_GRP1, OPC2_ACK, RES_HYP);
      tr(7'b1011000, 1'b1, CRM_GRP0, OPC2_ACK, RES_UNDEF);
      acc(1'b1, 1'b0, CRM_GRP1, OPC2_GRP0_EN, 32'h0, 1'b0);
      check({31'h0, virtual_group0_enable}, 32'h1);
   endtask

   // Reset in mid-run with the enable set: it must fall back to zero
   task automatic t_mid_reset();
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      check({31'h0, virtual_group0_enable}, 32'h0);
      check({24'h0, running_priority}, 32'hff);
      rd_chk(CRM_GRP1, OPC2_GRP0_EN, 32'h0, 1'b0);
   endtask

   // Main sequence: reset, fill the list, then each scenario
   initial begin
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      lr(2'h0, 1'b0, 1'b1, 8'h30, 24'h000020);
      lr(2'h1, 1'b1, 1'b1, 8'h20, 24'h1abcde);
      lr(2'h2, 1'b1, 1'b1, 8'h50, 24'h000040);
      lr(2'h3, 1'b0, 1'b0, 8'h10, 24'h000033);
      t_reset();
      t_enable();
      t_ack0();
      t_grp1();
      t_traps();
      t_mid_reset();
      tally_and_finish();
   end
endmodule
